// File: logic/wdtnmi_cfg.svh
// Purpose : constants of the watchdog timer with non-maskable interrupt
// Assumes : included by its bare name wherever the values are needed
// Notes   : offsets are register indices; byte address is four times each
`ifndef WDTNMI_CFG_SVH
`define WDTNMI_CFG_SVH

// ****************************************************************
// register map
// ****************************************************************
`define WDT_ADDR_W   18
`define WDT_CTL_IDX  16'hff07
`define WDT_STS_IDX  16'hff08
`define WDT_MSK_IDX  16'hff09
`define WDT_CNT_IDX  16'hff0a

// ****************************************************************
// fields and reset values
// ****************************************************************
`define WDT_EN_BIT   1
`define WDT_CLR_BIT  0
`define WDT_EN_RST   1'b1
`define WDT_CNT_W    10
`define WDT_CNT_MAX  10'h3ff
`define WDT_CNT_RST  10'h000
`define WDT_EV_W     2
`define WDT_EV_TMO   0
`define WDT_EV_ACK   1
`define WDT_NMI_VEC  16'h0100

// ****************************************************************
// timing
// ****************************************************************
`define WDT_CLK_HZ   10000000
`define WDT_TICK_HZ  256
`define WDT_TICK_DIV (`WDT_CLK_HZ / `WDT_TICK_HZ)
`define WDT_DIV_W    16

`endif

// File: logic/wdtnmi_pkg.sv
// Purpose : types of the watchdog timer with non-maskable interrupt
// Assumes : wdtnmi_cfg.svh supplies the widths
// Notes   : state of the top module is one packed struct
`include "wdtnmi_cfg.svh"

package wdtnmi_pkg;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [`WDT_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [31:0]            writedata;
    logic [3:0]             byteenable;
  } wdtnmi_avs_req_t;

  typedef struct packed {
    logic sp_pair_set;
    logic cpu_halted;
    logic nmi_ack;
  } wdtnmi_cpu_in_t;

  typedef struct packed {
    logic        nmi_req;
    logic        halt_wake;
    logic [15:0] nmi_vector;
  } wdtnmi_cpu_out_t;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    NMI_IDLE = 2'b01,
    NMI_PEND = 2'b10
  } wdtnmi_nmi_e_t;

  typedef struct packed {
    logic [`WDT_DIV_W-1:0] div;
    logic                  tick;
    logic [`WDT_CNT_W-1:0] cnt;
    logic                  en;
    wdtnmi_nmi_e_t         nmi;
    logic [`WDT_EV_W-1:0]  sts;
    logic [`WDT_EV_W-1:0]  msk;
    logic                  ack;
    logic [31:0]           rdata;
    logic [15:0]           vec;
  } wdtnmi_state_t;

endpackage

// File: logic/wdtnmi_top.sv
// Purpose : watchdog timer raising a non-maskable interrupt to the core
// Assumes : core-side inputs are on ref_clk; bus is Avalon-MM slave
// Notes   : a 10-bit counter at 256 Hz overflows after four seconds
//
// Behaviour
// (R1) counter advances on a 256 Hz tick divided down from the clock
// (R2) after reset the watchdog counts with no software action
// (R3) no clear within the 3-4 s window raises the interrupt
// (R4) 10-bit counter; interrupt when its last stage overflows
// (R5) counting goes on while halted; the interrupt wakes the core
// (R6) the request ignores the core's interrupt-enable flag
// (R7) request is withheld until both stack pointer halves are written
// (R8) the interrupt vectors to program address 0100H
// (R9) enable bit D1 is read/write; 0 stops counting and interrupt
// (R10) reset loads the enable bit with 1
// (R11) writing 1 to clear bit D0 zeroes the counter; 0 does nothing
// (R12) clear bit is write-only and reads as 0
// (R13) software clears the counter more often than every 3 s
// (R14) software not using the watchdog disables it early after reset
// (R15) reset zeroes the counter so the first window starts at release
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "wdtnmi_cfg.svh"

module wdtnmi_top #(
  parameter int TICK_DIV = `WDT_TICK_DIV
) (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire wdtnmi_pkg::wdtnmi_avs_req_t avs_req,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  input  wire wdtnmi_pkg::wdtnmi_cpu_in_t  cpu_in,
  output wdtnmi_pkg::wdtnmi_cpu_out_t     cpu_out,
  output logic                            irq
);
  import wdtnmi_pkg::*;

  // ****************************************************************
  // state and its reset value
  // ****************************************************************
  localparam wdtnmi_state_t RST_STATE = '{
    div   : '0,
    tick  : 1'b0,
    cnt   : `WDT_CNT_RST,
    en    : `WDT_EN_RST,
    nmi   : NMI_IDLE,
    sts   : '0,
    msk   : '0,
    ack   : 1'b0,
    rdata : 32'h0000_0000,
    vec   : `WDT_NMI_VEC
  };

  localparam logic [`WDT_DIV_W-1:0] DIV_LAST =
    `WDT_DIV_W'(TICK_DIV - 1);

  wdtnmi_state_t        s_r;
  wdtnmi_state_t        s_nxt;
  logic                 req;
  logic                 aligned;
  logic [15:0]          idx;
  logic                 wr_do;
  logic                 ctl_wr;
  logic                 clr_wr;
  logic                 sts_wr;
  logic                 msk_wr;
  logic                 overflow;
  logic                 nmi_taken;
  logic [`WDT_EV_W-1:0] ev;
  logic [`WDT_EV_W-1:0] sts_clr;
  logic [31:0]          rd_mux;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // one wait cycle on every access; readdata is prepared in that cycle
  always_comb begin
    req     = avs_req.read | avs_req.write;
    aligned = avs_req.address[1:0] == 2'b00;
    idx     = avs_req.address[`WDT_ADDR_W-1:2];
    wr_do   = s_r.ack & avs_req.write & avs_req.byteenable[0] & aligned;
    ctl_wr  = wr_do & (idx == `WDT_CTL_IDX);
    sts_wr  = wr_do & (idx == `WDT_STS_IDX);
    msk_wr  = wr_do & (idx == `WDT_MSK_IDX);
    clr_wr  = ctl_wr & avs_req.writedata[`WDT_CLR_BIT]; // see (R11)
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        `WDT_CTL_IDX: begin
          // clear bit and upper bits read as zero
          rd_mux[`WDT_EN_BIT] = s_r.en; // see (R9)
          rd_mux[`WDT_CLR_BIT] = 1'b0; // see (R12)
        end
        `WDT_STS_IDX: rd_mux[`WDT_EV_W-1:0] = s_r.sts;
        `WDT_MSK_IDX: rd_mux[`WDT_EV_W-1:0] = s_r.msk;
        `WDT_CNT_IDX: rd_mux[`WDT_CNT_W-1:0] = s_r.cnt;
        default:      rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.vec  = `WDT_NMI_VEC;

    // bus handshake
    s_nxt.ack = req & ~s_r.ack;
    if (req && !s_r.ack) begin
      s_nxt.rdata = rd_mux;
    end

    // prescaler free-runs so a clear does not stretch the next tick
    if (s_r.div == DIV_LAST) begin
      s_nxt.div  = '0;
      s_nxt.tick = 1'b1; // see (R1)
    end else begin
      s_nxt.div = s_r.div + `WDT_DIV_W'(1);
    end

    // enable bit
    if (ctl_wr) begin
      s_nxt.en = avs_req.writedata[`WDT_EN_BIT]; // see (R9)
    end

    // counter: ignores halt, clear beats a coincident tick
    overflow = s_r.en & s_r.tick & (s_r.cnt == `WDT_CNT_MAX) &
               ~clr_wr; // see (R3) (R4)
    if (clr_wr) begin
      s_nxt.cnt = `WDT_CNT_RST; // see (R11)
    end else if (s_r.en && s_r.tick) begin
      s_nxt.cnt = s_r.cnt + `WDT_CNT_W'(1); // see (R2) (R5)
    end

    // interrupt request state
    nmi_taken = 1'b0;
    case (s_r.nmi)
      NMI_IDLE: begin
        if (overflow) begin
          s_nxt.nmi = NMI_PEND;
        end
      end
      NMI_PEND: begin
        if (!s_r.en) begin
          s_nxt.nmi = NMI_IDLE; // see (R9)
        end else if (cpu_in.nmi_ack && cpu_in.sp_pair_set) begin
          s_nxt.nmi = NMI_IDLE;
          nmi_taken = 1'b1;
        end
      end
      default: s_nxt.nmi = NMI_IDLE;
    endcase

    // sticky events; a new event beats a same-cycle clear
    ev = '0;
    ev[`WDT_EV_TMO] = overflow;
    ev[`WDT_EV_ACK] = nmi_taken;
    sts_clr = sts_wr ? avs_req.writedata[`WDT_EV_W-1:0] : '0;
    s_nxt.sts = (s_r.sts & ~sts_clr) | ev;
    if (msk_wr) begin
      s_nxt.msk = avs_req.writedata[`WDT_EV_W-1:0];
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= RST_STATE; // see (R10) (R15)
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // the interrupt-enable flag of the core is deliberately not an input
  always_comb begin
    avs_waitrequest    = req & ~s_r.ack;
    avs_readdata       = s_r.rdata;
    cpu_out.nmi_req    = (s_r.nmi == NMI_PEND) & s_r.en &
                         cpu_in.sp_pair_set; // see (R6) (R7)
    cpu_out.halt_wake  = cpu_out.nmi_req & cpu_in.cpu_halted; // see (R5)
    cpu_out.nmi_vector = s_r.vec; // see (R8)
    irq                = |(s_r.sts & s_r.msk);
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  tick_period_a: assert property ( // see (R1)
    @(posedge ref_clk) disable iff (srst)
    s_r.tick |-> $past(s_r.div) == DIV_LAST && s_r.div == '0)
    else $error("tick not at end of prescaler period");

  reset_enable_a: assert property ( // see (R10)
    @(posedge ref_clk) disable iff (srst)
    $past(srst) |-> s_r.en == 1'b1 && s_r.nmi == NMI_IDLE)
    else $error("enable not set after reset");

  reset_count_a: assert property ( // see (R15)
    @(posedge ref_clk) disable iff (srst)
    $past(srst) |-> s_r.cnt == `WDT_CNT_RST)
    else $error("counter not zero after reset");

  overflow_req_a: assert property ( // see (R3)
    @(posedge ref_clk) disable iff (srst)
    s_r.en && s_r.tick && s_r.cnt == `WDT_CNT_MAX && !clr_wr
    |=> s_r.nmi == NMI_PEND && s_r.cnt == `WDT_CNT_RST
        && s_r.sts[`WDT_EV_TMO])
    else $error("overflow did not raise request");

  no_early_a: assert property ( // see (R4)
    @(posedge ref_clk) disable iff (srst)
    $rose(s_r.nmi == NMI_PEND) |-> $past(s_r.cnt) == `WDT_CNT_MAX)
    else $error("request before last stage overflow");

  clear_zero_a: assert property ( // see (R11)
    @(posedge ref_clk) disable iff (srst)
    clr_wr |=> s_r.cnt == `WDT_CNT_RST ##1 s_r.cnt == `WDT_CNT_RST
               || s_r.tick == 1'b0 || s_r.cnt == `WDT_CNT_W'(1))
    else $error("clear did not zero counter");

  disabled_hold_a: assert property ( // see (R9)
    @(posedge ref_clk) disable iff (srst)
    !s_r.en && !clr_wr |=> $stable(s_r.cnt) && !cpu_out.nmi_req)
    else $error("counter moved while disabled");

  read_clear_a: assert property ( // see (R12)
    @(posedge ref_clk) disable iff (srst)
    avs_req.read && !avs_waitrequest
    && avs_req.address == {`WDT_CTL_IDX, 2'b00}
    |-> avs_readdata[`WDT_CLR_BIT] == 1'b0
        && avs_readdata[`WDT_EN_BIT] == s_r.en)
    else $error("control read back wrong");

  sp_gate_a: assert property ( // see (R7)
    @(posedge ref_clk) disable iff (srst)
    !cpu_in.sp_pair_set |-> !cpu_out.nmi_req)
    else $error("request while stack pointer unset");

  vector_a: assert property ( // see (R8)
    @(posedge ref_clk) disable iff (srst)
    cpu_out.nmi_req |-> cpu_out.nmi_vector == `WDT_NMI_VEC)
    else $error("wrong interrupt vector");

  halt_wake_a: assert property ( // see (R5)
    @(posedge ref_clk) disable iff (srst)
    s_r.nmi == NMI_PEND && s_r.en && cpu_in.sp_pair_set
    && cpu_in.cpu_halted |-> cpu_out.halt_wake)
    else $error("halt not released by request");

  bus_wait_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  // ****************************************************************
  // tick, counter, enable, request, status, mask and register read checks
  // ****************************************************************
  tick_gap_a: assert property ( // see (R1)
    @(posedge ref_clk) disable iff (srst)
    s_r.tick |=> !s_r.tick)
    else $error("tick pulses back to back");

  count_step_a: assert property ( // see (R2)
    @(posedge ref_clk) disable iff (srst)
    s_r.en && s_r.tick && !clr_wr
    |=> s_r.cnt == $past(s_r.cnt) + `WDT_CNT_W'(1))
    else $error("counter did not step on tick");

  count_hold_a: assert property ( // see (R1)
    @(posedge ref_clk) disable iff (srst)
    !s_r.tick && !clr_wr |=> $stable(s_r.cnt))
    else $error("counter moved without a tick");

  halt_count_a: assert property ( // see (R5)
    @(posedge ref_clk) disable iff (srst)
    cpu_in.cpu_halted && s_r.en && s_r.tick && !clr_wr
    |=> !$stable(s_r.cnt))
    else $error("counter stopped while core halted");

  enable_write_a: assert property ( // see (R9)
    @(posedge ref_clk) disable iff (srst)
    ctl_wr |=> s_r.en == $past(avs_req.writedata[`WDT_EN_BIT]))
    else $error("enable bit not written");

  enable_hold_a: assert property ( // see (R9)
    @(posedge ref_clk) disable iff (srst)
    !ctl_wr |=> $stable(s_r.en))
    else $error("enable bit changed without a write");

  ack_take_a: assert property ( // see (R6)
    @(posedge ref_clk) disable iff (srst)
    s_r.nmi == NMI_PEND && s_r.en && cpu_in.sp_pair_set && cpu_in.nmi_ack
    |=> s_r.nmi == NMI_IDLE && s_r.sts[`WDT_EV_ACK])
    else $error("taken request not retired");

  ack_refused_a: assert property ( // see (R7)
    @(posedge ref_clk) disable iff (srst)
    s_r.nmi == NMI_PEND && s_r.en && !cpu_in.sp_pair_set
    |=> s_r.nmi == NMI_PEND)
    else $error("request lost while stack pointer unset");

  idle_no_req_a: assert property ( // see (R3)
    @(posedge ref_clk) disable iff (srst)
    s_r.nmi == NMI_IDLE |-> !cpu_out.nmi_req)
    else $error("request without a pending overflow");

  status_sticky_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_r.sts[`WDT_EV_TMO] && !sts_wr |=> s_r.sts[`WDT_EV_TMO])
    else $error("timeout event lost without a clear");

  status_clear_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    sts_wr && avs_req.writedata[`WDT_EV_TMO] && !overflow
    |=> !s_r.sts[`WDT_EV_TMO])
    else $error("timeout event not cleared");

  mask_write_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    msk_wr |=> s_r.msk == $past(avs_req.writedata[`WDT_EV_W-1:0]))
    else $error("mask not written");

  unmapped_read_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    avs_req.read && !avs_waitrequest
    && !(idx inside {`WDT_CTL_IDX, `WDT_STS_IDX, `WDT_MSK_IDX, `WDT_CNT_IDX})
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped register read not zero");

  ctl_upper_a: assert property ( // see (R12)
    @(posedge ref_clk) disable iff (srst)
    avs_req.read && !avs_waitrequest
    && avs_req.address == {`WDT_CTL_IDX, 2'b00}
    |-> avs_readdata[31:2] == 30'h0000_0000)
    else $error("unused control bits not zero");

endmodule

// File: bench/wdtnmi_core_model.sv
// Purpose : core-side partner that takes the watchdog request
// Assumes : same clock as the watchdog; ack pulse lasts one cycle
// Notes   : acknowledge rises ack_dly+1 cycles after the request is first seen
`timescale 1ns/10ps

module wdtnmi_core_model (
  input  wire logic            ref_clk,
  input  wire logic            srst,
  input  wdtnmi_pkg::wdtnmi_cpu_out_t cpu_out,
  input  wire logic            sp_set,
  input  wire logic            halt,
  input  wire logic [3:0]      ack_dly,
  output wdtnmi_pkg::wdtnmi_cpu_in_t  cpu_in
);
  import wdtnmi_pkg::*;

  logic [3:0] wait_r;
  logic       ack_r;

  assign cpu_in = '{sp_set, halt, ack_r};

  // taken even with interrupts disabled; only with the stack set
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_r <= 4'h0;
      ack_r  <= 1'b0;
    end else if (ack_r) begin
      wait_r <= 4'h0;
      ack_r  <= 1'b0;
    end else if (cpu_out.nmi_req && sp_set) begin
      if (wait_r >= ack_dly) begin
        ack_r <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule

// File: bench/wdtnmi_top_tb.sv
// Purpose : self-checking bench of the watchdog timer
// Assumes : tick divider shortened to 4, so a window is 4096 cycles
// Notes   : read results are queued and compared by a monitor
`timescale 1ns/10ps
`include "wdtnmi_cfg.svh"

module wdtnmi_top_tb;
  import wdtnmi_pkg::*;
  logic            ref_clk = 1'b0;
  logic            srst;
  wdtnmi_avs_req_t avs_req;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  wdtnmi_cpu_in_t  cpu_in;
  wdtnmi_cpu_out_t cpu_out;
  logic            irq;
  logic            sp_set;
  logic            halt;
  logic [3:0]      ack_dly;
  logic [31:0]     seed;
  logic [31:0]     expq[$];
  int              miscompares = 0;
  int              samples_checked = 0;
  int              n;

  always #50 ref_clk = ~ref_clk;

  wdtnmi_top #(.TICK_DIV(4)) DUT (.ref_clk(ref_clk), .srst(srst),
    .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_in(cpu_in),
    .cpu_out(cpu_out), .irq(irq));

  wdtnmi_core_model core (.ref_clk(ref_clk), .srst(srst),
    .cpu_out(cpu_out), .sp_set(sp_set), .halt(halt),
    .ack_dly(ack_dly), .cpu_in(cpu_in));

  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [15:0] idx,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_req <= '{{idx, 2'b00}, rd, ~rd, d, be};
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    expq.push_back(exp);
    bus(1'b1, idx, 32'h0, 4'hf);
  endtask

  task automatic wait_nmi(input logic lvl);
    n = 0;
    while (cpu_out.nmi_req !== lvl && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    // a wait that runs out is a failure in its own right
    if (n >= 5000) miscompares++;
  endtask

  always @(posedge ref_clk) begin
    if (!srst && avs_req.read && !avs_waitrequest) begin
      check(avs_readdata, expq.pop_front());
    end
  end

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end

  // ****
  // scenarios
  // ****
  initial begin
    srst    = 1'b1;
    avs_req = '0;
    sp_set  = 1'b0;
    halt    = 1'b0;
    seed    = lfsr(32'hca54065d);
    ack_dly = seed[3:0] | 4'h4;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`WDT_CTL_IDX, 32'h2);
    rd(`WDT_MSK_IDX, 32'h0);
    rd(`WDT_STS_IDX, 32'h0);
    rd(16'h0000, 32'h0);
    bus(1'b0, `WDT_MSK_IDX, 32'h3, 4'hf);
    bus(1'b0, `WDT_CTL_IDX, 32'h0, 4'he);
    rd(`WDT_CTL_IDX, 32'h2);
    sp_set <= 1'b1;
    halt   <= 1'b1;
    seed = lfsr(seed);
    bus(1'b0, `WDT_CTL_IDX, {seed[31:2], 2'b11}, 4'hf);
    wait_nmi(1'b1);
    check(32'(n >= 4088 && n <= 4100), 32'h1);
    check(32'(cpu_out.halt_wake), 32'h1);
    check(32'(cpu_out.nmi_vector), 32'h100);
    check(32'(irq), 32'h1);
    wait_nmi(1'b0);
    rd(`WDT_STS_IDX, 32'h3);
    bus(1'b0, `WDT_STS_IDX, 32'h3, 4'hf);
    // the cleared status only shows after the edge that takes the write
    @(posedge ref_clk);
    check(32'(irq), 32'h0);
    halt   <= 1'b0;
    // stack not yet set: the request must be held back
    sp_set <= 1'b0;
    bus(1'b0, `WDT_CTL_IDX, 32'h3, 4'hf);
    repeat (4200) @(posedge ref_clk);
    check(32'(cpu_out.nmi_req), 32'h0);
    rd(`WDT_STS_IDX, 32'h1);
    sp_set <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(32'(cpu_out.nmi_req), 32'h1);
    wait_nmi(1'b0);
    bus(1'b0, `WDT_STS_IDX, 32'h3, 4'hf);
    // software servicing in time never sees a timeout
    repeat (3) begin
      repeat (3000) @(posedge ref_clk);
      bus(1'b0, `WDT_CTL_IDX, 32'h3, 4'hf);
    end
    rd(`WDT_STS_IDX, 32'h0);
    bus(1'b0, `WDT_CTL_IDX, 32'h0, 4'hf);
    repeat (4300) @(posedge ref_clk);
    check(32'(cpu_out.nmi_req), 32'h0);
    rd(`WDT_CTL_IDX, 32'h0);
    rd(`WDT_STS_IDX, 32'h0);
    // mid-run reset while disabled must restore count and enable
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`WDT_CNT_IDX, 32'h0);
    rd(`WDT_CTL_IDX, 32'h2);
    finish_test();
  end
endmodule
